// [pkg/pcacmp_defines.vh]
`ifndef PCACMP_DEFINES_VH
`define PCACMP_DEFINES_VH

// axi byte offsets; module n registers at base + 4*n
`define PCACMP_MODE_BASE     8'h00
`define PCACMP_CMPL_BASE     8'h20
`define PCACMP_CMPH_BASE     8'h40
`define PCACMP_CTRL_OFF      8'h60
`define PCACMP_COUNT_OFF     8'h64
`define PCACMP_FLAG_OFF      8'h68
`define PCACMP_MASK_OFF      8'h6c
`define PCACMP_WDT_OFF       8'h70

// mode register field positions
`define PCACMP_IRQEN_BIT     0
`define PCACMP_PWM_BIT       1
`define PCACMP_TOGGLE_BIT    2
`define PCACMP_MATEN_BIT     3
`define PCACMP_CAPN_BIT      4
`define PCACMP_CAPP_BIT      5
`define PCACMP_CMPEN_BIT     6

// control and watchdog register fields
`define PCACMP_RUN_BIT       0
`define PCACMP_WDOG_EN_BIT   0

// reset values
`define PCACMP_MODE_RST      7'h00
`define PCACMP_BYTE_RST      8'h00
`define PCACMP_COUNT_RST     16'h0000

// axi responses
`define PCACMP_RESP_OKAY     2'b00
`define PCACMP_RESP_SLVERR   2'b10

`endif

// [core/pcacmp_channel.v]
`timescale 1ns/1ps
`include "pcacmp_defines.vh"

module pcacmp_channel #(
  parameter WDOG = 0
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        reset,
  input  wire        clkEn,
  // shared counter
  input  wire [15:0] count,
  input  wire        countStep,
  // configuration
  input  wire [6:0]  mode,
  input  wire [7:0]  cmpLow,
  input  wire [7:0]  cmpHigh,
  input  wire        wdogEnable,
  // results
  output reg         pinOut,
  output wire        matchEvent,
  output wire        wdogHit
);

  wire cmpEn   = mode[`PCACMP_CMPEN_BIT];
  wire matchEn = mode[`PCACMP_MATEN_BIT];
  wire pwmEn   = mode[`PCACMP_PWM_BIT];
  wire capAny  = mode[`PCACMP_CAPN_BIT] | mode[`PCACMP_CAPP_BIT];

  // full equality, evaluated only when the counter advances
  wire equal16 = countStep && (count == {cmpHigh, cmpLow});
  wire pwmOn   = cmpEn && pwmEn;

  assign matchEvent = cmpEn && matchEn && !pwmEn && equal16;
  assign wdogHit = (WDOG != 0) && wdogEnable && cmpEn && matchEn && !capAny
                   && !pwmEn && equal16;

  always @(posedge clk_sys) begin
    if (reset) begin
      pinOut <= 1'b0;
    end else if (clkEn) begin
      if (pwmOn) begin
        pinOut <= (count[7:0] >= cmpLow);
      end else if (matchEvent && mode[`PCACMP_TOGGLE_BIT]) begin
        pinOut <= ~pinOut;
      end
    end
  end

endmodule // pcacmp_channel

// [core/pcacmp_axi_slave.v]
`timescale 1ns/1ps

module pcacmp_axi_slave (
  // clock and reset
  input  wire        clk_sys,
  input  wire        reset,
  input  wire        clkEn,
  // axi write
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // register side
  output reg         wrStrobe,
  output reg  [7:0]  wrAddr,
  output reg  [31:0] wrData,
  output reg  [3:0]  wrStrb,
  output wire [7:0]  rdAddr,
  input  wire [31:0] rdData,
  input  wire [1:0]  rdResp,
  input  wire [1:0]  wrResp
);

  reg haveAw;
  reg haveW;

  assign rdAddr = s_axi_araddr;

  always @(posedge clk_sys) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'b00;
      s_axi_rdata   <= 32'h00000000;
      haveAw        <= 1'b0;
      haveW         <= 1'b0;
      wrStrobe      <= 1'b0;
      wrAddr        <= 8'h00;
      wrData        <= 32'h00000000;
      wrStrb        <= 4'h0;
    end else if (clkEn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      wrStrobe      <= 1'b0;
      if (s_axi_awvalid && !haveAw && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        haveAw        <= 1'b1;
        wrAddr        <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !haveW && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
        haveW        <= 1'b1;
        wrData       <= s_axi_wdata;
        wrStrb       <= s_axi_wstrb;
      end
      if (haveAw && haveW && !s_axi_bvalid) begin
        wrStrobe     <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrResp;
        haveAw       <= 1'b0;
        haveW        <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdData;
        s_axi_rresp   <= rdResp;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // pcacmp_axi_slave

// [core/pcacmp_top.v]
// Notes on behaviour
// - compare-enable plus match-enable: equality is a match
// - interrupt needs event flag and its enable
// - low compare write clears compare-enable
// - high compare write sets compare-enable
// - compare-enable also read/written via mode register
// - toggle mode inverts pin on each match
// - all modules PWM, shared frequency, own duty
// - PWM low below duty byte, else high
// - duty reloads from high byte at wrap
// - PWM needs PWM-enable and compare-enable
// - only module 4 has watchdog
// - watchdog match makes internal reset
// - watchdog reset never drives external pin
// - watchdog enable bit gates watchdog resets
// - match sets module event flag
// - watchdog mode: compare, match, no capture/PWM
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pcacmp_defines.vh"

module pcacmp_top #(
  parameter NMOD = 5,
  parameter WDOG_MOD = 4
) (
  // clock and reset
  input  wire            clk_sys,
  input  wire            reset,
  input  wire            clkEn,
  // axi4-lite slave
  input  wire [7:0]      s_axi_awaddr,
  input  wire            s_axi_awvalid,
  output wire            s_axi_awready,
  input  wire [31:0]     s_axi_wdata,
  input  wire [3:0]      s_axi_wstrb,
  input  wire            s_axi_wvalid,
  output wire            s_axi_wready,
  output wire [1:0]      s_axi_bresp,
  output wire            s_axi_bvalid,
  input  wire            s_axi_bready,
  input  wire [7:0]      s_axi_araddr,
  input  wire            s_axi_arvalid,
  output wire            s_axi_arready,
  output wire [31:0]     s_axi_rdata,
  output wire [1:0]      s_axi_rresp,
  output wire            s_axi_rvalid,
  input  wire            s_axi_rready,
  // module outputs and events
  output reg  [NMOD-1:0] moduleIoPin,
  output reg             irq,
  output reg             watchdogReset
);

  reg  [6:0]      mode    [0:NMOD-1];
  reg  [7:0]      cmpLow  [0:NMOD-1];
  reg  [7:0]      cmpHigh [0:NMOD-1];
  reg  [15:0]     count;
  reg             counterRun;
  reg             watchdogEnable;
  reg  [NMOD-1:0] eventFlag;
  reg  [NMOD-1:0] eventMask;
  reg             countStep;

  wire            wrStrobe;
  wire [7:0]      wrAddr;
  wire [31:0]     wrData;
  wire [3:0]      wrStrb;
  wire [7:0]      rdAddr;
  reg  [31:0]     rdData;
  reg  [1:0]      rdResp;
  reg  [1:0]      wrResp;
  wire [NMOD-1:0] pinNow;
  wire [NMOD-1:0] matchNow;
  wire [NMOD-1:0] wdogNow;
  wire [NMOD-1:0] irqEnable;
  wire [7:0]      wrByte = wrData[7:0];
  wire            wrLane0 = wrStrobe && wrStrb[0];

  // decodes an address into a hit bit plus module index, 0 if out of range
  function [3:0] modIndex;
    input [7:0] addr;
    input [7:0] base;
    reg   [7:0] offset;
    begin
      // byte offset inside the group, word aligned
      offset = addr - base;
      if (addr >= base && addr < base + 8'd4 * NMOD[7:0]) begin
        modIndex = {1'b1, offset[4:2]};
      end else begin
        modIndex = 4'h0;
      end
    end
  endfunction

  // decoded module slots, bit 3 marks a hit
  wire [3:0]      wrModeIdx = modIndex(wrAddr, `PCACMP_MODE_BASE);
  wire [3:0]      wrLowIdx  = modIndex(wrAddr, `PCACMP_CMPL_BASE);
  wire [3:0]      wrHighIdx = modIndex(wrAddr, `PCACMP_CMPH_BASE);
  wire [3:0]      rdModeIdx = modIndex(rdAddr, `PCACMP_MODE_BASE);
  wire [3:0]      rdLowIdx  = modIndex(rdAddr, `PCACMP_CMPL_BASE);
  wire [3:0]      rdHighIdx = modIndex(rdAddr, `PCACMP_CMPH_BASE);

  pcacmp_axi_slave uBus (
    .clk_sys       (clk_sys),
    .reset         (reset),
    .clkEn         (clkEn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wrStrobe      (wrStrobe),
    .wrAddr        (wrAddr),
    .wrData        (wrData),
    .wrStrb        (wrStrb),
    .rdAddr        (rdAddr),
    .rdData        (rdData),
    .rdResp        (rdResp),
    .wrResp        (wrResp)
  );

  genvar g;
  generate
    for (g = 0; g < NMOD; g = g + 1) begin : gCh
      pcacmp_channel #(
        .WDOG (g == WDOG_MOD)
      ) uCh (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .clkEn      (clkEn),
        .count      (count),
        .countStep  (countStep),
        .mode       (mode[g]),
        .cmpLow     (cmpLow[g]),
        .cmpHigh    (cmpHigh[g]),
        .wdogEnable (watchdogEnable),
        .pinOut     (pinNow[g]),
        .matchEvent (matchNow[g]),
        .wdogHit    (wdogNow[g])
      );
      assign irqEnable[g] = mode[g][`PCACMP_IRQEN_BIT];
    end
  endgenerate

  // write response: mapped check
  always @* begin
    wrResp = `PCACMP_RESP_SLVERR;
    if (wrModeIdx[3]) begin
      wrResp = `PCACMP_RESP_OKAY;
    end else if (wrLowIdx[3]) begin
      wrResp = `PCACMP_RESP_OKAY;
    end else if (wrHighIdx[3]) begin
      wrResp = `PCACMP_RESP_OKAY;
    end else if (wrAddr == `PCACMP_CTRL_OFF || wrAddr == `PCACMP_FLAG_OFF
                 || wrAddr == `PCACMP_MASK_OFF || wrAddr == `PCACMP_WDT_OFF) begin
      wrResp = `PCACMP_RESP_OKAY;
    end else if (wrAddr == `PCACMP_COUNT_OFF) begin
      wrResp = `PCACMP_RESP_OKAY;
    end
  end

  // read mux
  always @* begin
    rdData = 32'h00000000;
    rdResp = `PCACMP_RESP_OKAY;
    if (rdModeIdx[3]) begin
      rdData = {25'h0000000, mode[rdModeIdx[2:0]]};
    end else if (rdLowIdx[3]) begin
      rdData = {24'h000000, cmpLow[rdLowIdx[2:0]]};
    end else if (rdHighIdx[3]) begin
      rdData = {24'h000000, cmpHigh[rdHighIdx[2:0]]};
    end else if (rdAddr[7:2] == `PCACMP_CTRL_OFF >> 2) begin
      rdData = {31'h00000000, counterRun};
    end else if (rdAddr[7:2] == `PCACMP_COUNT_OFF >> 2) begin
      rdData = {16'h0000, count};
    end else if (rdAddr[7:2] == `PCACMP_FLAG_OFF >> 2) begin
      rdData = {{(32-NMOD){1'b0}}, eventFlag};
    end else if (rdAddr[7:2] == `PCACMP_MASK_OFF >> 2) begin
      rdData = {{(32-NMOD){1'b0}}, eventMask};
    end else if (rdAddr[7:2] == `PCACMP_WDT_OFF >> 2) begin
      rdData = {31'h00000000, watchdogEnable};
    end else begin
      rdResp = `PCACMP_RESP_SLVERR;
    end
  end

  // write selects for the single registers
  wire            wrCtrl  = wrStrobe && wrStrb[0] && (wrAddr == `PCACMP_CTRL_OFF);
  wire            wrCount = wrStrobe && (wrAddr == `PCACMP_COUNT_OFF);
  wire            wrFlag  = wrStrobe && wrStrb[0] && (wrAddr == `PCACMP_FLAG_OFF);
  wire            wrMask  = wrStrobe && wrStrb[0] && (wrAddr == `PCACMP_MASK_OFF);
  wire            wrWdog  = wrStrobe && wrStrb[0] && (wrAddr == `PCACMP_WDT_OFF);

  // shared counter, advances every enabled cycle while running
  always @(posedge clk_sys) begin
    if (reset) begin
      count      <= `PCACMP_COUNT_RST;
      counterRun <= 1'b0;
      countStep  <= 1'b0;
    end else if (clkEn) begin
      countStep <= counterRun;
      if (counterRun) begin
        count <= count + 16'h0001;
      end
      // a software load overrides the increment
      if (wrCount && wrStrb[0]) begin
        count[7:0] <= wrData[7:0];
      end
      if (wrCount && wrStrb[1]) begin
        count[15:8] <= wrData[15:8];
      end
      if (wrCtrl) begin
        counterRun <= wrData[`PCACMP_RUN_BIT];
      end
    end
  end

  // per-module mode and compare bytes
  integer i;
  always @(posedge clk_sys) begin
    if (reset) begin
      for (i = 0; i < NMOD; i = i + 1) begin
        mode[i]    <= `PCACMP_MODE_RST;
        cmpLow[i]  <= `PCACMP_BYTE_RST;
        cmpHigh[i] <= `PCACMP_BYTE_RST;
      end
    end else if (clkEn) begin
      for (i = 0; i < NMOD; i = i + 1) begin
        if (wrLane0 && wrModeIdx == (4'h8 | i[3:0])) begin
          mode[i] <= wrByte[6:0];
        end
        // compare-enable follows the last low or high byte write
        if (wrLane0 && wrLowIdx == (4'h8 | i[3:0])) begin
          cmpLow[i] <= wrByte;
          mode[i][`PCACMP_CMPEN_BIT] <= 1'b0;
        end else if (mode[i][`PCACMP_PWM_BIT] && mode[i][`PCACMP_CMPEN_BIT]
                     && counterRun && count[7:0] == 8'hff) begin
          cmpLow[i] <= cmpHigh[i];
        end
        if (wrLane0 && wrHighIdx == (4'h8 | i[3:0])) begin
          cmpHigh[i] <= wrByte;
          mode[i][`PCACMP_CMPEN_BIT] <= 1'b1;
        end
      end
    end
  end

  // interrupt mask and watchdog enable
  always @(posedge clk_sys) begin
    if (reset) begin
      watchdogEnable <= 1'b0;
      eventMask      <= {NMOD{1'b0}};
    end else if (clkEn) begin
      if (wrMask) begin
        eventMask <= wrData[NMOD-1:0];
      end
      if (wrWdog) begin
        watchdogEnable <= wrData[`PCACMP_WDOG_EN_BIT];
      end
    end
  end

  // event flags, a set wins over write-one-to-clear in the same cycle
  always @(posedge clk_sys) begin
    if (reset) begin
      eventFlag <= {NMOD{1'b0}};
    end else if (clkEn) begin
      if (wrFlag) begin
        eventFlag <= (eventFlag & ~wrData[NMOD-1:0]) | matchNow;
      end else begin
        eventFlag <= eventFlag | matchNow;
      end
    end
  end

  // registered outputs
  always @(posedge clk_sys) begin
    if (reset) begin
      moduleIoPin   <= {NMOD{1'b0}};
      irq           <= 1'b0;
      watchdogReset <= 1'b0;
    end else if (clkEn) begin
      moduleIoPin   <= pinNow;
      irq           <= |(eventFlag & irqEnable & eventMask);
      // internal reset pulse only, no external pin path
      watchdogReset <= |wdogNow;
    end
  end

endmodule // pcacmp_top

// [testbench/pcacmp_properties.sv]
`timescale 1ns/1ps
module pcacmp_properties #(
  parameter NMOD = 5
) (
  input wire            clk_sys,
  input wire            reset,
  input wire            s_axi_awready,
  input wire            s_axi_wready,
  input wire [1:0]      s_axi_bresp,
  input wire            s_axi_bvalid,
  input wire            s_axi_bready,
  input wire            s_axi_arready,
  input wire [31:0]     s_axi_rdata,
  input wire            s_axi_rvalid,
  input wire            s_axi_rready,
  input wire [NMOD-1:0] moduleIoPin,
  input wire            irq,
  input wire            watchdogReset
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held past one cycle");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  resp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("bad write response code");
  ar_answer_a: assert property (s_axi_arready |-> s_axi_rvalid)
    else $error("read answer not with arready");
  write_answer_a: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid)
    else $error("write answer late");
  wdog_pulse_a: assert property (watchdogReset |=> !watchdogReset)
    else $error("watchdog request longer than one cycle");
  reset_quiet_a: assert property (disable iff (1'b0) reset |=>
    !irq && !watchdogReset && moduleIoPin == '0) else $error("outputs active after reset");
  cover property (watchdogReset);
  cover property ($rose(irq));
  cover property ($changed(moduleIoPin));
endmodule // pcacmp_properties

bind pcacmp_top pcacmp_properties #(.NMOD(NMOD)) i_pcacmp_properties (
  .clk_sys(clk_sys), .reset(reset), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .moduleIoPin(moduleIoPin),
  .irq(irq), .watchdogReset(watchdogReset));

// [testbench/pcacmp_pin_load.sv]
`timescale 1ns/1ps
module pcacmp_pin_load (
  // clock and control
  input  wire        clk_sys,
  input  wire        clear,
  input  wire [2:0]  sel,
  // observed pins
  input  wire [4:0]  pins,
  // measurements
  output reg  [15:0] highCnt,
  output reg  [15:0] edgeCnt
);
  reg last;
  // counts high cycles and level changes of one pin
  always @(posedge clk_sys) begin
    last <= pins[sel];
    if (clear) begin
      highCnt <= 16'h0000;
      edgeCnt <= 16'h0000;
    end else begin
      if (pins[sel]) highCnt <= highCnt + 16'h0001;
      if (pins[sel] !== last) edgeCnt <= edgeCnt + 16'h0001;
    end
  end
endmodule // pcacmp_pin_load

// [testbench/test_counter_array_compare_pwm_wdt.sv]
`timescale 1ns/1ps
module test_counter_array_compare_pwm_wdt;
  reg         clk_sys, reset, clkEn, awvalid, wvalid, bready, arvalid, rready, loadClr;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata, rv;
  reg  [3:0]  wstrb;
  reg  [2:0]  loadSel;
  reg  [1:0]  resp;
  reg  [31:0] rows [0:5];
  wire        awready, wready, bvalid, arready, rvalid, irq, wdogRst;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [4:0]  pins;
  wire [15:0] highCnt, edgeCnt;
  integer     err_total, n_tests, i, k, w0;
  integer     wdCnt = 0;

  pcacmp_top i_pcacmp_top (.clk_sys(clk_sys), .reset(reset), .clkEn(clkEn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .moduleIoPin(pins), .irq(irq), .watchdogReset(wdogRst));
  pcacmp_pin_load i_pcacmp_pin_load (.clk_sys(clk_sys), .clear(loadClr), .sel(loadSel),
    .pins(pins), .highCnt(highCnt), .edgeCnt(edgeCnt));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (wdogRst === 1'b1) wdCnt <= wdCnt + 1;

  task chk(input string nm, input [31:0] e, input [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    integer c;
    reg aw, w;
    aw = 0; w = 0; c = 0;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    while (!(aw && w) && c < 50) begin
      @(posedge clk_sys); c++;
      if (awready === 1'b1) begin aw = 1; awvalid <= 1'b0; end
      if (wready === 1'b1) begin w = 1; wvalid <= 1'b0; end
    end
    while (bvalid !== 1'b1 && c < 100) begin @(posedge clk_sys); c++; end
    resp = bresp;
    chk("write answer", 32'h1, {31'h0, bvalid});
  endtask
  task rd(input [7:0] a);
    integer c;
    c = 0;
    araddr <= a; arvalid <= 1'b1;
    while (arready !== 1'b1 && c < 50) begin @(posedge clk_sys); c++; end
    arvalid <= 1'b0; rready <= 1'b1;
    @(posedge clk_sys);
    while (rvalid !== 1'b1 && c < 100) begin @(posedge clk_sys); c++; end
    chk("read answer", 32'h1, {31'h0, rvalid});
    rv = rdata; resp = rresp; rready <= 1'b0;
  endtask
  task waitPin(input integer b, input v);
    for (k = 0; k < 60 && pins[b] !== v; k++) @(posedge clk_sys);
    chk("toggle pin", {31'h0, v}, {31'h0, pins[b]});
  endtask
  task measure;
    @(posedge clk_sys);
    loadClr <= 1'b1;
    @(posedge clk_sys);
    loadClr <= 1'b0;
    repeat (513) @(posedge clk_sys);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #(8 * 40000);
    err_total++;
    report_and_stop;
  end

  initial begin
    clkEn = 1'b1; reset = 1'b1; awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0;
    bready = 1'b1; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    wstrb = 4'hf; loadSel = 3'h2; loadClr = 1'b0; err_total = 0; n_tests = 0;
    // write addr, write byte, read addr, expected byte
    rows[0] = 32'h00_48_00_48;
    rows[1] = 32'h20_10_00_08;
    rows[2] = 32'h40_00_00_48;
    rows[3] = 32'h00_08_00_08;
    rows[4] = 32'h4c_55_4c_55;
    rows[5] = 32'h70_00_70_00;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rd(8'h00); chk("mode reset", 32'h0, rv);
    rd(8'h64); chk("counter reset", 32'h0, rv);
    for (i = 0; i < 6; i++) begin
      wr(rows[i][31:24], {24'h0, rows[i][23:16]});
      rd(rows[i][15:8]);
      chk("register row", {24'h0, rows[i][7:0]}, rv);
    end
    wr(8'h7c, 32'h1); chk("unmapped write", 32'h2, {30'h0, resp});
    rd(8'h7c); chk("unmapped read", 32'h2, {30'h0, resp});
    // match on module 0, mask still clear
    wr(8'h00, 32'h49); wr(8'h20, 32'h20); wr(8'h40, 32'h00);
    wr(8'h64, 32'h0); wr(8'h60, 32'h1);
    for (k = 0; k < 20 && rv[0] !== 1'b1; k++) rd(8'h68);
    chk("event flag", 32'h1, {31'h0, rv[0]});
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(8'h6c, 32'h1); repeat (3) @(posedge clk_sys);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(8'h68, 32'h1); repeat (3) @(posedge clk_sys);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // high-speed output on module 1
    wr(8'h64, 32'h100);
    wr(8'h04, 32'h4c); wr(8'h24, 32'h40); wr(8'h44, 32'h00);
    wr(8'h64, 32'h30); waitPin(1, 1'b1);
    wr(8'h64, 32'h30); waitPin(1, 1'b0);
    // pwm on module 2, duty 0x40 then 0x80
    wr(8'h28, 32'h40); wr(8'h48, 32'h40); wr(8'h08, 32'h42);
    measure; chk("pwm high cycles", 32'd384, {16'h0, highCnt});
    wr(8'h48, 32'h80); repeat (300) @(posedge clk_sys);
    measure; chk("pwm reload", 32'd256, {16'h0, highCnt});
    wr(8'h08, 32'h02);
    measure; chk("pwm off edges", 32'h0, {16'h0, edgeCnt});
    // watchdog on module 4, first disabled
    wr(8'h10, 32'h48); wr(8'h30, 32'h80); wr(8'h50, 32'h00);
    w0 = wdCnt;
    wr(8'h64, 32'h70); repeat (60) @(posedge clk_sys);
    chk("watchdog disabled", w0, wdCnt);
    wr(8'h70, 32'h1); wr(8'h64, 32'h10); repeat (30) @(posedge clk_sys);
    chk("watchdog only module 4", w0, wdCnt);
    wr(8'h64, 32'h70);
    for (k = 0; k < 60 && wdCnt == w0; k++) @(posedge clk_sys);
    chk("watchdog pulse", w0 + 1, wdCnt);
    report_and_stop;
  end
endmodule // test_counter_array_compare_pwm_wdt
